// File: spl_consts.svh
// Purpose: timing, offsets, field positions and reset values of the servo loop
// Assumes: 10 MHz system clock, four axes
// Notes: definitions only
`ifndef SPL_CONSTS_SVH
`define SPL_CONSTS_SVH

`define SPL_CLK_PERIOD_NS 100
`define SPL_UPDATE_PERIOD_NS 488000

// coefficient limits: offsets are signed counts, gains are hundredths
`define SPL_OFFSET_MAX 32'sh0000_7F80
`define SPL_GAIN_MAX 32'h0000_61A7
`define SPL_RUNAWAY_LIMIT 32'sh0000_8000
`define SPL_DAC_MAX 16'sh7FFF
`define SPL_DAC_MIN 16'sh8000
`define SPL_INTEG_MAX 24'sh7F_FFFF
`define SPL_DIV100_MUL 13'h028F
`define SPL_DIV100_SHIFT 16

// parameter slot inside an axis block
`define SPL_K_OPEN_OFS 3'h0
`define SPL_K_CLOSED_OFS 3'h1
`define SPL_K_PROP 3'h2
`define SPL_K_ACCEL 3'h6
`define SPL_K_MODE 3'h7

// global register offsets
`define SPL_REG_CMD 8'h80
`define SPL_REG_ARG 8'h84
`define SPL_REG_STATUS 8'h88
`define SPL_REG_INT_CLR 8'h8C
`define SPL_REG_INT_EN 8'h90
`define SPL_REG_STATE 8'h94
`define SPL_POS_PAGE 3'h5

// command bits
`define SPL_CMD_ARCHIVE 0
`define SPL_CMD_RESTORE 1
`define SPL_CMD_FACTORY 2
`define SPL_CMD_LOADPOS 3

// status bits
`define SPL_ST_ARCH_DONE 4
`define SPL_ST_TICK 5
`define SPL_ST_RESTORED 6
`define SPL_ST_WIDTH 7

// factory defaults in hundredths
`define SPL_FACT_PROP 16'h03E8
`define SPL_FACT_INTEG 16'h0064
`define SPL_FACT_DERIV 16'h3E80

// marker of a valid archive, value is arbitrary
`define SPL_ARCH_KEY 16'hA5C3
`define SPL_KEY_ADDR 5'h07

`endif

// File: spl_pkg.sv
// Purpose: types shared by the servo loop files
// Assumes: nothing
// Notes: constants live in spl_consts.svh
package spl_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } spl_bus_req_s;

  typedef enum logic [2:0] {
    CP_IDLE = 3'b000,
    CP_KEY = 3'b001,
    CP_KEYCHK = 3'b010,
    CP_REST = 3'b011,
    CP_ARCH = 3'b100,
    CP_FACT = 3'b101
  } spl_copy_e;

  typedef enum logic [2:0] {
    CA_IDLE = 3'b000,
    CA_ERR = 3'b001,
    CA_MUL = 3'b010,
    CA_OUT = 3'b011
  } spl_calc_e;

endpackage : spl_pkg

// File: spl_param_store.sv
// Purpose: nonvolatile store of archived tuning words
// Assumes: contents survive resetn_i, only the read register is reset
// Notes: read data appear one cycle after the address
`timescale 1ns/10ps
module spl_param_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // read port
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : spl_param_store

// File: spl_servo_loop.sv
// Purpose: four-axis servo position loop with PID, feedforward and offsets
// Assumes: encoder and profile velocity inputs are synchronous to clk_i
// Notes: one shared multiplier walks the five terms of each axis in turn
// Function
// - one update of four axes per 488 us
// - open loop drives the programmable open-loop offset coefficient
// - closed loop adds offset coefficient to PID
// - offsets accepted only within +-32640
// - P, I, D gains 0..249.99 per axis
// - load position zero aligns commanded with encoder
// - velocity feedforward term scaled per axis
// - acceleration feedforward term scaled per axis
// - archive writes parameters, reused after reset
// - error beyond 32768 counts disables the loop
// - encoder and commanded position readable separately
// - restore factory or archived defaults on command
`timescale 1ns/10ps
`include "spl_consts.svh"
module spl_servo_loop #(
  parameter int TICK_CYCLES = `SPL_UPDATE_PERIOD_NS / `SPL_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire spl_pkg::spl_bus_req_s bus_i,
  output logic [31:0] rdata_o,
  // encoder and profile feedback
  input wire logic [3:0][31:0] enc_pos_i,
  input wire logic [3:0][15:0] prof_vel_i,
  // amplifier side
  output logic [3:0][15:0] dac_o,
  output logic [3:0] hold_on_o,
  output logic tick_o,
  output logic irq_o
);
  localparam int AXES = 4;

  logic [12:0] tick_cnt;
  logic [15:0] prm [32];
  logic [3:0] hold_on;
  logic signed [31:0] cmd_pos [AXES];
  logic signed [23:0] integ [AXES];
  logic signed [17:0] e_prev [AXES];
  logic signed [15:0] v_prev [AXES];
  logic [31:0] load_arg;
  logic [`SPL_ST_WIDTH-1:0] status;
  logic [`SPL_ST_WIDTH-1:0] int_en;
  spl_pkg::spl_copy_e cp_state;
  logic [4:0] cp_cnt;
  logic rd_pend;
  logic [4:0] rd_idx;
  spl_pkg::spl_calc_e ca_state;
  logic [1:0] ax;
  logic [2:0] term;
  logic signed [47:0] acc;
  logic signed [17:0] err_c;
  logic signed [18:0] derr;
  logic [15:0] mem_rdata;

  // update tick
  wire tick = (tick_cnt == 13'(TICK_CYCLES - 1));
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt <= 13'h0000;
    end else begin
      tick_cnt <= tick ? 13'h0000 : tick_cnt + 13'h0001;
    end
  end
  assign tick_o = tick;

  // register decode
  wire [1:0] w_ax = bus_i.addr[6:5];
  wire [2:0] w_k = bus_i.addr[4:2];
  wire [4:0] w_idx = {w_ax, w_k};
  wire in_axis = ~bus_i.addr[7];
  wire busy = (cp_state != spl_pkg::CP_IDLE);
  wire signed [31:0] w_sval = $signed(bus_i.wdata);
  wire offset_ok = (w_sval <= `SPL_OFFSET_MAX) && (w_sval >= -`SPL_OFFSET_MAX);
  wire gain_ok = (bus_i.wdata <= `SPL_GAIN_MAX);
  wire is_offset = (w_k == `SPL_K_OPEN_OFS) || (w_k == `SPL_K_CLOSED_OFS);
  wire val_ok = is_offset ? offset_ok : gain_ok;
  wire prm_wr = bus_i.wr && in_axis && (w_k != `SPL_K_MODE) && val_ok && !busy;
  wire mode_wr = bus_i.wr && in_axis && (w_k == `SPL_K_MODE);
  wire cmd_wr = bus_i.wr && (bus_i.addr == `SPL_REG_CMD);
  wire arch_go = cmd_wr && bus_i.wdata[`SPL_CMD_ARCHIVE] && !busy;
  wire rest_go = cmd_wr && bus_i.wdata[`SPL_CMD_RESTORE] && !busy;
  wire fact_go = cmd_wr && bus_i.wdata[`SPL_CMD_FACTORY] && !busy;
  wire loadpos_go = cmd_wr && bus_i.wdata[`SPL_CMD_LOADPOS];
  wire [1:0] loadpos_ax = bus_i.wdata[5:4];
  wire clr_wr = bus_i.wr && (bus_i.addr == `SPL_REG_INT_CLR);

  // parameter copy engine
  wire factory_load = (cp_state == spl_pkg::CP_FACT);
  wire rest_wr = rd_pend && (rd_idx[2:0] != `SPL_K_MODE);
  wire arch_we = (cp_state == spl_pkg::CP_ARCH);
  wire [15:0] arch_word = (cp_cnt[2:0] == `SPL_K_MODE) ? `SPL_ARCH_KEY : prm[cp_cnt];
  wire [4:0] mem_raddr = (cp_state == spl_pkg::CP_KEY) ? `SPL_KEY_ADDR : cp_cnt;
  wire last_word = (cp_cnt == 5'h1F);

  spl_param_store #(
    .WIDTH(16),
    .DEPTH(32),
    .AW(5)
  ) u_store (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .we_i(arch_we),
    .waddr_i(cp_cnt),
    .wdata_i(arch_word),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // reset starts in CP_KEY so archived values take over after every reset that finds the archive key
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cp_state <= spl_pkg::CP_KEY;
      cp_cnt <= 5'h00;
      rd_pend <= 1'b0;
      rd_idx <= 5'h00;
    end else begin
      rd_pend <= (cp_state == spl_pkg::CP_REST);
      rd_idx <= cp_cnt;
      unique case (cp_state)
        spl_pkg::CP_IDLE: begin
          cp_cnt <= 5'h00;
          if (arch_go) begin
            cp_state <= spl_pkg::CP_ARCH;
          end else if (rest_go) begin
            cp_state <= spl_pkg::CP_KEY;
          end else if (fact_go) begin
            cp_state <= spl_pkg::CP_FACT;
          end
        end
        spl_pkg::CP_KEY: cp_state <= spl_pkg::CP_KEYCHK;
        spl_pkg::CP_KEYCHK: begin
          // a blank or never written store falls back to factory values
          if (mem_rdata == `SPL_ARCH_KEY) begin
            cp_state <= spl_pkg::CP_REST;
          end else begin
            cp_state <= spl_pkg::CP_FACT;
          end
        end
        spl_pkg::CP_REST, spl_pkg::CP_ARCH: begin
          cp_cnt <= cp_cnt + 5'h01;
          if (last_word) begin
            cp_state <= spl_pkg::CP_IDLE;
          end
        end
        spl_pkg::CP_FACT: cp_state <= spl_pkg::CP_IDLE;
        default: cp_state <= spl_pkg::CP_IDLE;
      endcase
    end
  end

  function automatic logic [15:0] factory_val(input logic [2:0] k);
    case (k)
      3'h2: factory_val = `SPL_FACT_PROP;
      3'h3: factory_val = `SPL_FACT_INTEG;
      3'h4: factory_val = `SPL_FACT_DERIV;
      default: factory_val = 16'h0000;
    endcase
  endfunction : factory_val

  // working parameters
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 32; i++) begin
        prm[i] <= factory_val(3'(i));
      end
    end else if (factory_load) begin
      for (int i = 0; i < 32; i++) begin
        prm[i] <= factory_val(3'(i));
      end
    end else if (rest_wr) begin
      prm[rd_idx] <= mem_rdata;
    end else if (prm_wr) begin
      prm[w_idx] <= bus_i.wdata[15:0];
    end
  end

  // loop arithmetic for the axis in hand
  wire signed [15:0] vel = $signed(prof_vel_i[ax]);
  wire signed [31:0] cmd_next = cmd_pos[ax] + 32'(vel);
  wire signed [31:0] err_full = cmd_next - $signed(enc_pos_i[ax]);
  wire run_hi = (err_full > `SPL_RUNAWAY_LIMIT);
  wire run_lo = (err_full < -`SPL_RUNAWAY_LIMIT);
  wire runaway = run_hi || run_lo;
  wire signed [17:0] err_sat = run_hi ? 18'sh0_8000 : (run_lo ? -18'sh0_8000 : err_full[17:0]);
  wire signed [24:0] integ_sum = 25'(integ[ax]) + 25'(err_sat);
  wire integ_hi = (integ_sum > 25'(`SPL_INTEG_MAX));
  wire integ_lo = (integ_sum < -25'(`SPL_INTEG_MAX));
  wire signed [23:0] integ_next = integ_hi ? `SPL_INTEG_MAX : (integ_lo ? -`SPL_INTEG_MAX : integ_sum[23:0]);
  wire signed [16:0] accel = 17'(vel) - 17'(v_prev[ax]);
  wire [15:0] coef = prm[{ax, 3'(term + `SPL_K_PROP)}];
  wire signed [24:0] operand =
    (term == 3'h0) ? 25'(err_c) :
    (term == 3'h1) ? 25'(integ[ax]) :
    (term == 3'h2) ? 25'(derr) :
    (term == 3'h3) ? 25'(vel) : 25'(accel);
  wire signed [41:0] product = operand * $signed({1'b0, coef});
  wire signed [60:0] scaled_full = acc * $signed({1'b0, `SPL_DIV100_MUL});
  wire signed [44:0] scaled = scaled_full[60:`SPL_DIV100_SHIFT];
  wire signed [44:0] loop_sum = scaled + 45'($signed(prm[{ax, `SPL_K_CLOSED_OFS}]));
  wire signed [15:0] loop_out =
    (loop_sum > 45'(`SPL_DAC_MAX)) ? `SPL_DAC_MAX :
    (loop_sum < 45'(`SPL_DAC_MIN)) ? `SPL_DAC_MIN : loop_sum[15:0];
  wire last_ax = (ax == 2'(AXES - 1));
  wire in_err = (ca_state == spl_pkg::CA_ERR);
  wire in_out = (ca_state == spl_pkg::CA_OUT);
  wire trip = in_err && runaway && hold_on[ax];

  // calculation sequencer, a few dozen cycles per update
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ca_state <= spl_pkg::CA_IDLE;
      ax <= 2'h0;
      term <= 3'h0;
      acc <= '0;
      err_c <= '0;
      derr <= '0;
    end else begin
      unique case (ca_state)
        spl_pkg::CA_IDLE: begin
          ax <= 2'h0;
          if (tick) begin
            ca_state <= spl_pkg::CA_ERR;
          end
        end
        spl_pkg::CA_ERR: begin
          err_c <= err_sat;
          derr <= 19'(err_sat) - 19'(e_prev[ax]);
          acc <= '0;
          term <= 3'h0;
          ca_state <= spl_pkg::CA_MUL;
        end
        spl_pkg::CA_MUL: begin
          acc <= acc + 48'(product);
          term <= term + 3'h1;
          if (term == 3'h4) begin
            ca_state <= spl_pkg::CA_OUT;
          end
        end
        spl_pkg::CA_OUT: begin
          ax <= ax + 2'h1;
          ca_state <= last_ax ? spl_pkg::CA_IDLE : spl_pkg::CA_ERR;
        end
        default: ca_state <= spl_pkg::CA_IDLE;
      endcase
    end
  end

  // per-axis loop state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < AXES; i++) begin
        cmd_pos[i] <= '0;
        integ[i] <= '0;
        e_prev[i] <= '0;
        v_prev[i] <= '0;
        dac_o[i] <= 16'h0000;
      end
    end else begin
      if (in_err) begin
        cmd_pos[ax] <= cmd_next;
        // integral only runs while the loop is closed
        integ[ax] <= (hold_on[ax] && !runaway) ? integ_next : 24'sh00_0000;
      end
      if (in_out) begin
        e_prev[ax] <= err_c;
        v_prev[ax] <= vel;
        dac_o[ax] <= hold_on[ax] ? loop_out : prm[{ax, `SPL_K_OPEN_OFS}];
      end
      for (int i = 0; i < AXES; i++) begin
        if (!hold_on[i]) begin
          integ[i] <= 24'sh00_0000;
        end
      end
      if (loadpos_go) begin
        // error becomes the argument, so an argument of zero zeroes it
        cmd_pos[loadpos_ax] <= $signed(enc_pos_i[loadpos_ax]) + $signed(load_arg);
      end
    end
  end

  // loop mode: a runaway trip beats a software write
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_on <= 4'h0;
    end else begin
      if (mode_wr) begin
        hold_on[w_ax] <= bus_i.wdata[0];
      end
      if (trip) begin
        hold_on[ax] <= 1'b0;
      end
    end
  end
  assign hold_on_o = hold_on;

  // sticky events, set wins over clear
  logic [`SPL_ST_WIDTH-1:0] ev_set;
  always_comb begin
    ev_set = '0;
    ev_set[ax] = trip;
    ev_set[`SPL_ST_ARCH_DONE] = arch_we && last_word;
    ev_set[`SPL_ST_TICK] = tick;
    ev_set[`SPL_ST_RESTORED] = rest_wr && (rd_idx == 5'h1F);
  end
  wire [`SPL_ST_WIDTH-1:0] clr_mask = clr_wr ? bus_i.wdata[`SPL_ST_WIDTH-1:0] : '0;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status <= '0;
      int_en <= '0;
      load_arg <= 32'h0000_0000;
    end else begin
      status <= (status & ~clr_mask) | ev_set;
      if (bus_i.wr && (bus_i.addr == `SPL_REG_INT_EN)) begin
        int_en <= bus_i.wdata[`SPL_ST_WIDTH-1:0];
      end
      if (bus_i.wr && (bus_i.addr == `SPL_REG_ARG)) begin
        load_arg <= bus_i.wdata;
      end
    end
  end
  assign irq_o = |(status & int_en);

  // read data, one cycle after the strobe, zero for unmapped offsets
  wire [15:0] r_prm = prm[w_idx];
  wire [31:0] r_axis = (w_k == `SPL_K_MODE) ? {31'h0000_0000, hold_on[w_ax]} :
    (is_offset ? {{16{r_prm[15]}}, r_prm} : {16'h0000, r_prm});
  wire pos_page = (bus_i.addr[7:5] == `SPL_POS_PAGE);
  wire [31:0] r_pos = bus_i.addr[2] ? cmd_pos[bus_i.addr[4:3]] : enc_pos_i[bus_i.addr[4:3]];
  wire [31:0] r_val =
    in_axis ? r_axis :
    pos_page ? r_pos :
    (bus_i.addr == `SPL_REG_ARG) ? load_arg :
    (bus_i.addr == `SPL_REG_STATUS) ? 32'(status) :
    (bus_i.addr == `SPL_REG_INT_EN) ? 32'(int_en) :
    (bus_i.addr == `SPL_REG_STATE) ? {27'h000_0000, busy, hold_on} : 32'h0000_0000;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (bus_i.rd) begin
      rdata_o <= r_val;
    end
  end
endmodule : spl_servo_loop

// File: spl_servo_loop_properties.sv
// Purpose: port-level checks of the servo loop
// Assumes: single clock, resetn_i low active
// Notes: bound into spl_servo_loop below
`timescale 1ns/10ps
module spl_servo_loop_properties #(
  parameter int TICK_CYCLES = 4880
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire spl_pkg::spl_bus_req_s bus_i,
  input wire logic [31:0] rdata_o,
  // loop side
  input wire logic [3:0][31:0] enc_pos_i,
  input wire logic [3:0][15:0] prof_vel_i,
  input wire logic [3:0][15:0] dac_o,
  input wire logic [3:0] hold_on_o,
  input wire logic tick_o,
  input wire logic irq_o
);
  logic [15:0] tick_gap;
  logic [7:0] since_tick;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // since_tick saturates, so a stuck tick cannot wrap into a false pass
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_gap <= 16'h0000;
      since_tick <= 8'hFF;
    end else if (tick_o) begin
      tick_gap <= 16'h0000;
      since_tick <= 8'h01;
    end else begin
      tick_gap <= tick_gap + 16'h0001;
      since_tick <= (since_tick == 8'hFF) ? since_tick : since_tick + 8'h01;
    end
  end
  a_tick_spacing: assert property (tick_o == (tick_gap == 16'(TICK_CYCLES - 1)))
    else $error("tick spacing wrong");
  a_dac_window: assert property (!$stable(dac_o) |-> since_tick <= 8'h28)
    else $error("dac changed outside update");
  a_rdata_hold: assert property (!$past(bus_i.rd) |-> $stable(rdata_o))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (bus_i.rd && bus_i.addr >= 8'hC0 |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_offset_range: assert property (bus_i.rd && bus_i.addr < 8'h80 && bus_i.addr[4:2] <= 3'h1
    |=> $signed(rdata_o) >= -32640 && $signed(rdata_o) <= 32640) else $error("offset out of range");
  a_gain_range: assert property (bus_i.rd && bus_i.addr < 8'h80 && bus_i.addr[4:2] inside {[3'h2:3'h6]}
    |=> rdata_o <= 32'h0000_61A7) else $error("gain out of range");
  a_state_mirror: assert property (bus_i.rd && bus_i.addr == 8'h94 |=> rdata_o[3:0] == $past(hold_on_o))
    else $error("state does not mirror loop mode");
  a_enc_report: assert property (bus_i.rd && bus_i.addr == 8'hA0 |=> rdata_o == $past(enc_pos_i[0]))
    else $error("encoder report wrong");
endmodule : spl_servo_loop_properties

bind spl_servo_loop spl_servo_loop_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_i(clk_i),
  .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o), .enc_pos_i(enc_pos_i), .prof_vel_i(prof_vel_i),
  .dac_o(dac_o), .hold_on_o(hold_on_o), .tick_o(tick_o), .irq_o(irq_o));

// File: spl_amp_model.sv
// Purpose: amplifier, motor and encoder of four axes
// Assumes: motion integrates the dac code once per update
// Notes: mechanics keep their position through a controller reset
`timescale 1ns/10ps
module spl_amp_model (
  // loop drive
  input wire logic clk_i,
  input wire logic [3:0][15:0] dac_i,
  input wire logic tick_i,
  // response divisor: small is a stiff, quick axis
  input wire logic [15:0] div_i,
  // encoder feedback
  output logic [3:0][31:0] enc_pos_o
);
  initial enc_pos_o = {4{32'h0000_0100}};
  always @(posedge clk_i) begin
    if (tick_i) begin
      for (int a = 0; a < 4; a++) begin
        enc_pos_o[a] <= enc_pos_o[a] + 32'(int'($signed(dac_i[a])) / int'(div_i));
      end
    end
  end
endmodule : spl_amp_model

// File: test_servo_pid_loop.sv
// Purpose: directed register-level tests of the servo loop
// Assumes: update period shortened to 64 clocks
// Notes: axis block at axis*0x20, globals from 0x80
`timescale 1ns/10ps
`include "spl_consts.svh"
module test_servo_pid_loop;
  localparam int TC = 64;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  spl_pkg::spl_bus_req_s bus = '0;
  logic [31:0] rdata;
  logic [3:0][31:0] enc;
  logic [3:0][15:0] vel = '0;
  logic [3:0][15:0] dac;
  logic [3:0] hold;
  logic tick;
  logic irq;
  logic [15:0] div = 16'h0010;
  logic [31:0] rd_v;
  logic [31:0] lim;
  logic [15:0] fact [8] = '{16'h0, 16'h0, 16'h03E8, 16'h0064, 16'h3E80, 16'h0, 16'h0, 16'h0};
  int n_mismatch = 0;
  int compares = 0;
  int n;

  always #50 clk_i = ~clk_i;

  spl_servo_loop #(.TICK_CYCLES(TC)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata),
    .enc_pos_i(enc), .prof_vel_i(vel), .dac_o(dac), .hold_on_o(hold), .tick_o(tick), .irq_o(irq));
  spl_amp_model amp_u (.clk_i(clk_i), .dac_i(dac), .tick_i(tick), .div_i(div), .enc_pos_o(enc));

  task automatic final_report;
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
    @(negedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask : rd

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd_v);
    check(what, exp, rd_v);
  endtask : rchk

  task automatic idle;
    for (int i = 0; i < 60; i++) begin
      rd(`SPL_REG_STATE, rd_v);
      if (rd_v[4] === 1'b0) break;
    end
    check("busy", 32'h0, {31'h0, rd_v[4]});
  endtask : idle

  task automatic wait_tick;
    for (int i = 0; i < 200; i++) begin
      @(negedge clk_i);
      if (tick === 1'b1) break;
    end
    // a missing tick is a failure in its own right
    if (tick !== 1'b1) n_mismatch++;
    @(posedge clk_i);
  endtask : wait_tick

  // axis 3 lands 28 edges after the tick
  task automatic wait_upd;
    wait_tick();
    repeat (32) @(posedge clk_i);
    @(negedge clk_i);
  endtask : wait_upd

  function automatic logic [15:0] out_of(input longint acc, input longint off);
    longint v;
    v = ((acc * longint'(`SPL_DIV100_MUL)) >>> 16) + off;
    v = (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
    return 16'(v);
  endfunction : out_of

  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    idle();
    for (int a = 0; a < 4; a++) for (int s = 0; s < 8; s++) rchk("factory", 8'(a * 32 + s * 4), fact[s]);
    rchk("unmapped", 8'hC0, 32'h0);
    for (int s = 0; s < 7; s++) begin
      lim = (s < 2) ? `SPL_OFFSET_MAX : `SPL_GAIN_MAX;
      wr(8'h40 + 8'(s * 4), lim);
      wr(8'h40 + 8'(s * 4), lim + 32'h1);
      rchk("limit", 8'h40 + 8'(s * 4), lim);
    end
    wr(8'h40, 32'hFFFF_8080);
    wr(8'h40, 32'hFFFF_807F);
    rchk("floor", 8'h40, 32'hFFFF_8080);
    for (int a = 0; a < 4; a++) wr(8'(a * 32), 32'(100 * (a + 1)));
    wait_upd();
    for (int a = 0; a < 4; a++) check("open dac", 32'(100 * (a + 1)), dac[a]);
    wait_tick();
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (tick !== 1'b1 && n < 200);
    check("tick gap", TC, n);
    div <= 16'h0400;
    wait_tick();
    wr(`SPL_REG_ARG, 32'h0);
    wr(`SPL_REG_CMD, 32'h0000_0008);
    rd(8'hA0, rd_v);
    check("enc", enc[0], rd_v);
    rchk("cmd pos", 8'hA4, enc[0]);
    wr(8'h00, 32'hFFFF_FF51);
    wr(8'h04, 32'hFFFF_FF51);
    for (int s = 2; s < 7; s++) wr(8'(s * 4), 32'h0);
    wr(8'h08, 32'h0000_0064);
    wr(8'h1C, 32'h0000_0001);
    wait_upd();
    check("offset dac", out_of(0, -175), dac[0]);
    wait_tick();
    wr(`SPL_REG_ARG, 32'h0000_00C8);
    wr(`SPL_REG_CMD, 32'h0000_0008);
    wait_upd();
    check("p dac", out_of(100 * 200, -175), dac[0]);
    wr(8'h08, 32'h0);
    wr(8'h14, 32'h0000_0064);
    @(posedge clk_i);
    vel[0] <= 16'h000A;
    wait_upd();
    check("vel dac", out_of(100 * 10, -175), dac[0]);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0000_0064);
    @(posedge clk_i);
    vel[0] <= 16'h001E;
    wait_upd();
    check("acc dac", out_of(100 * 20, -175), dac[0]);
    wait_upd();
    check("acc off", out_of(0, -175), dac[0]);
    wr(8'h18, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h08, `SPL_GAIN_MAX);
    @(posedge clk_i);
    vel[0] <= 16'h0000;
    wr(`SPL_REG_ARG, 32'h0000_7530);
    wr(`SPL_REG_CMD, 32'h0000_0008);
    wait_upd();
    check("sat hi", out_of(24999 * 30000, 0), dac[0]);
    wr(`SPL_REG_ARG, 32'hFFFF_8AD0);
    wr(`SPL_REG_CMD, 32'h0000_0008);
    wait_upd();
    check("sat lo", out_of(-24999 * 30000, 0), dac[0]);
    wr(`SPL_REG_INT_EN, 32'h0000_0001);
    wr(`SPL_REG_ARG, 32'h0000_9C40);
    wr(`SPL_REG_CMD, 32'h0000_0008);
    wait_upd();
    check("hold", 32'h0, hold[0]);
    check("irq", 32'h1, irq);
    wr(`SPL_REG_STATUS, 32'h0);
    rd(`SPL_REG_STATUS, rd_v);
    check("status", 32'h3, {rd_v[5], rd_v[0]});
    wr(`SPL_REG_INT_EN, 32'h0);
    check("irq masked", 32'h0, irq);
    wr(`SPL_REG_INT_EN, 32'h0000_0001);
    wr(`SPL_REG_INT_CLR, 32'h0000_0001);
    check("irq cleared", 32'h0, irq);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h0000_0064);
    wr(`SPL_REG_ARG, 32'h0000_0064);
    wr(`SPL_REG_CMD, 32'h0000_0008);
    wr(8'h1C, 32'h0000_0001);
    wait_upd();
    check("integ clear", out_of(100 * 100, 0), dac[0]);
    wait_upd();
    check("integ sum", out_of(100 * 200, 0), dac[0]);
    wr(8'h1C, 32'h0);
    wr(8'h28, 32'h0000_0309);
    wr(`SPL_REG_CMD, 32'h0000_0001);
    idle();
    wr(8'h28, 32'h0000_0005);
    wr(`SPL_REG_CMD, 32'h0000_0002);
    idle();
    rchk("restore", 8'h28, 32'h0000_0309);
    wr(`SPL_REG_CMD, 32'h0000_0004);
    idle();
    rchk("factory back", 8'h28, 32'h0000_03E8);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    idle();
    rchk("archived", 8'h28, 32'h0000_0309);
    final_report();
  end

  // whole sequence needs about 1200 clocks
  initial begin
    #(TC * 100 * 400);
    n_mismatch++;
    final_report();
  end
endmodule : test_servo_pid_loop
